// ==== core/cmpctl_top.sv ====
// Comparator control and status wrapper with Wishbone register access.
// Assumes an analog comparator core, a timer clock source sampled as a
// synchronous level, and a single 250 MHz clock with synchronous reset.
`timescale 1ns/100ps
`default_nettype none

// Contract
// - Enable bit powers comparator on
// - Result bit reflects polarity-adjusted comparison
// - Pin-route bit drives pin when direction clear
// - Polarity bit inverts result everywhere
// - Speed bit selects fast mode, resets one
// - Hysteresis bit enables input hysteresis
// - Sync bit latches on timer falling edge
// - Rising edge enable sets event flag
// - Falling edge enable sets event flag
// - Plus select: pin, DAC, fixed reference, ground
// - Minus select bit picks second pin
// - Mirror register shows result bit
// - Unimplemented bits read as zero
// - Analog-configured port pins read zero
// - Result latched every cycle; pin unlatched unless sync bit set
// - Polarity or enable toggle may flag
module cmpctl_top
  import cmpctl_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone classic slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Analog core
  input wire logic analog_raw_i,
  output logic comparator_on_o,
  output logic speed_power_select_o,
  output logic hysteresis_on_o,
  output logic [1:0] plus_input_select_o,
  output logic minus_input_select_o,
  // Timer and pin
  input wire logic timer_clk_src_i,
  input wire logic pin_direction_i,
  output logic timer_gate_o,
  output logic result_pin_o,
  output logic result_pin_oe_o,
  // Port pins
  input wire logic [CMPCTL_PORT_W-1:0] port_pins_i,
  input wire logic [CMPCTL_PORT_W-1:0] port_analog_i,
  output logic irq_o
);

  logic [7:0] ctrl_a_reg;
  logic [7:0] ctrl_b_reg;
  logic result_reg;
  logic timer_clk_reg;
  logic sync_result_reg;
  logic status_reg;
  logic irq_en_reg;
  logic [CMPCTL_PORT_W-1:0] port_reg;
  logic [CMPCTL_PORT_W-1:0] port_next;
  logic result_next;
  logic ext_result;
  logic timer_fall;
  logic rise_hit;
  logic fall_hit;
  logic event_hit;
  logic clear_hit;
  logic [31:0] rd_data;

  // Decoded register selects
  logic sel_a;
  logic sel_b;
  logic sel_mirror;
  logic sel_status;
  logic sel_clear;
  logic sel_en;
  logic sel_port;

  // Bus handshake
  logic req;
  logic commit;
  logic wr_any;
  logic wr_lane0;
  logic wr_a;
  logic wr_b;
  logic wr_clr;
  logic wr_en;
  logic rd_any;

  // One answer per request; a request still held after its ack is taken again
  typedef enum logic [0:0] {
    CMPCTL_BUS_IDLE = 1'b0,
    CMPCTL_BUS_ANSWER = 1'b1
  } cmpctl_bus_e;

  cmpctl_bus_e bus_reg;
  cmpctl_bus_e bus_next;

  function automatic logic hit(input logic [7:0] adr, input logic [7:0] off);
    hit = (adr[7:2] == off[7:2]);
  endfunction : hit

  assign sel_a = hit(wb_adr_i, CMPCTL_OFF_CTRL_A);
  assign sel_b = hit(wb_adr_i, CMPCTL_OFF_CTRL_B);
  assign sel_mirror = hit(wb_adr_i, CMPCTL_OFF_MIRROR);
  assign sel_status = hit(wb_adr_i, CMPCTL_OFF_STATUS);
  assign sel_clear = hit(wb_adr_i, CMPCTL_OFF_CLEAR);
  assign sel_en = hit(wb_adr_i, CMPCTL_OFF_IRQ_EN);
  assign sel_port = hit(wb_adr_i, CMPCTL_OFF_PORT);

  always_comb begin
    bus_next = bus_reg;
    case (bus_reg)
      CMPCTL_BUS_IDLE: begin
        if (wb_cyc_i && wb_stb_i) begin
          bus_next = CMPCTL_BUS_ANSWER;
        end
      end
      CMPCTL_BUS_ANSWER: begin
        bus_next = CMPCTL_BUS_IDLE;
      end
      default: begin
        bus_next = CMPCTL_BUS_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      bus_reg <= CMPCTL_BUS_IDLE;
    end else begin
      bus_reg <= bus_next;
    end
  end

  // Request taken in idle; writes land when the master sees ack
  assign req = (bus_reg == CMPCTL_BUS_IDLE) && wb_cyc_i && wb_stb_i;
  assign commit = (bus_reg == CMPCTL_BUS_ANSWER) && wb_cyc_i && wb_stb_i;
  assign wr_any = commit && wb_we_i;
  // Registers are at most 8 bits wide, so only lane 0 carries them
  assign wr_lane0 = wr_any && wb_sel_i[0];
  assign wr_a = wr_lane0 && sel_a;
  assign wr_b = wr_lane0 && sel_b;
  assign wr_clr = wr_lane0 && sel_clear;
  assign wr_en = wr_lane0 && sel_en;
  assign rd_any = req && !wb_we_i;

  // polarity applied before result, timer and pin
  // enable gates raw output before inversion
  assign result_next = (analog_raw_i && ctrl_a_reg[CMPCTL_A_ON]) ^ ctrl_a_reg[CMPCTL_A_INV];

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      result_reg <= 1'b0;
    end else begin
      result_reg <= result_next;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      timer_clk_reg <= 1'b0;
    end else begin
      timer_clk_reg <= timer_clk_src_i;
    end
  end

  assign timer_fall = timer_clk_reg && !timer_clk_src_i;

  // capture on falling edge of timer source
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sync_result_reg <= 1'b0;
    end else if (timer_fall) begin
      sync_result_reg <= result_next;
    end
  end

  // unsynced path uses the unlatched polarity-adjusted value
  assign ext_result = ctrl_a_reg[CMPCTL_A_SYNC] ? sync_result_reg : result_next;

  assign rise_hit = ctrl_b_reg[CMPCTL_B_RISE] && !result_reg && result_next;
  assign fall_hit = ctrl_b_reg[CMPCTL_B_FALL] && result_reg && !result_next;
  assign event_hit = rise_hit || fall_hit;
  assign clear_hit = wr_clr && wb_dat_i[0];

  // set wins over a clear in the same cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      status_reg <= 1'b0;
    end else if (event_hit) begin
      status_reg <= 1'b1;
    end else if (clear_hit) begin
      status_reg <= 1'b0;
    end
  end

  // Enable is bit 0 of its register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_en_reg <= 1'b0;
    end else if (wr_en) begin
      irq_en_reg <= wb_dat_i[0];
    end
  end

  // speed bit resets to one via reset value
  // masked write keeps unimplemented bits zero
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_a_reg <= CMPCTL_A_RESET;
    end else if (wr_a) begin
      ctrl_a_reg <= wb_dat_i[7:0] & CMPCTL_A_WMASK;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_b_reg <= CMPCTL_B_RESET;
    end else if (wr_b) begin
      ctrl_b_reg <= wb_dat_i[7:0] & CMPCTL_B_WMASK;
    end
  end

  for (genvar g = 0; g < CMPCTL_PORT_W; g++) begin : g_port
    assign port_next[g] = port_analog_i[g] ? 1'b0 : port_pins_i[g];
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      port_reg <= '0;
    end else begin
      port_reg <= port_next;
    end
  end

  always_comb begin
    rd_data = CMPCTL_UNMAPPED;
    if (sel_a) begin
      rd_data[7:0] = ctrl_a_reg & CMPCTL_A_WMASK;
      rd_data[CMPCTL_A_RESULT] = result_reg;
    end else if (sel_b) begin
      rd_data[7:0] = ctrl_b_reg & CMPCTL_B_WMASK;
    end else if (sel_mirror) begin
      rd_data[0] = result_reg;
    end else if (sel_status) begin
      rd_data[0] = status_reg;
    end else if (sel_en) begin
      rd_data[0] = irq_en_reg;
    end else if (sel_port) begin
      rd_data[CMPCTL_PORT_W-1:0] = port_reg;
    end
  end

  // Ack stands for the one answer cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= (bus_next == CMPCTL_BUS_ANSWER);
    end
  end

  // Read data zero on write answers and between answers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_dat_o <= '0;
    end else if (rd_any) begin
      wb_dat_o <= rd_data;
    end else begin
      wb_dat_o <= '0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      comparator_on_o <= 1'b0;
    end else begin
      comparator_on_o <= ctrl_a_reg[CMPCTL_A_ON];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      speed_power_select_o <= 1'b1;
    end else begin
      speed_power_select_o <= ctrl_a_reg[CMPCTL_A_SPEED];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      hysteresis_on_o <= 1'b0;
    end else begin
      hysteresis_on_o <= ctrl_a_reg[CMPCTL_A_HYS];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      plus_input_select_o <= CMPCTL_PLUS_PIN;
    end else begin
      plus_input_select_o <= ctrl_b_reg[CMPCTL_B_PLUS_HI:CMPCTL_B_PLUS_LO];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      minus_input_select_o <= 1'b0;
    end else begin
      minus_input_select_o <= ctrl_b_reg[CMPCTL_B_MINUS];
    end
  end

  // timer gate follows the external result
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      timer_gate_o <= 1'b0;
    end else begin
      timer_gate_o <= ext_result;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      result_pin_o <= 1'b0;
    end else begin
      result_pin_o <= ext_result;
    end
  end

  // drive only while routed and direction clear
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      result_pin_oe_o <= 1'b0;
    end else begin
      result_pin_oe_o <= ctrl_a_reg[CMPCTL_A_PIN] && !pin_direction_i;
    end
  end

  // Level interrupt from flag and enable
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= status_reg && irq_en_reg;
    end
  end

endmodule : cmpctl_top

`default_nettype wire

// ==== dv/cmpctl_analog_model.sv ====
// Behavioural comparator core and timer clock source.
// Assumes bench-driven 8-bit level codes and the block's one clock.
`timescale 1ns/100ps
`default_nettype none
module cmpctl_analog_model (
  input wire logic clk_i,
  input wire logic on_i,
  input wire logic [1:0] plus_sel_i,
  input wire logic minus_sel_i,
  input wire logic [5:0][7:0] level_i,
  input wire logic tmr_run_i,
  output logic raw_o,
  output logic tmr_clk_o
);
  logic [7:0] plus_v;
  logic [1:0] div_reg = 2'h0;
  assign plus_v = (plus_sel_i == 2'h3) ? 8'h00 : level_i[plus_sel_i];
  // Timer source stands still unless the bench runs it
  assign tmr_clk_o = div_reg[1];
  always_ff @(posedge clk_i) begin
    raw_o <= on_i && (plus_v > (minus_sel_i ? level_i[4] : level_i[3]));
    if (tmr_run_i) div_reg <= div_reg + 2'h1;
  end
endmodule : cmpctl_analog_model
`default_nettype wire

// ==== dv/cmpctl_checker.sv ====
// Port checker for the comparator control block.
// Assumes one clock and synchronous active-high reset.
`timescale 1ns/100ps
`default_nettype none
module cmpctl_checker (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  input wire logic analog_raw_i,
  input wire logic pin_direction_i,
  input wire logic result_pin_oe_o,
  input wire logic comparator_on_o,
  input wire logic speed_power_select_o,
  input wire logic hysteresis_on_o,
  input wire logic irq_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence s_req;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  a_ack_answer: assert property (s_req |=> wb_ack_o)
    else $error("ack missing");
  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack too long");
  a_ack_cause: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without request");
  a_pin_dir: assert property (result_pin_oe_o |-> !$past(pin_direction_i))
    else $error("pin driven as input");
  a_irq_cause: assert property ($rose(irq_o) |->
    $past(analog_raw_i, 2) != $past(analog_raw_i, 3) || $past(wb_ack_o, 2) || $past(wb_ack_o, 3))
    else $error("irq rose without edge");
  a_irq_drop: assert property ($fell(irq_o) |-> $past(wb_ack_o, 2))
    else $error("irq fell without write");
  a_reset_vals: assert property ($fell(rst_i) |-> speed_power_select_o && !comparator_on_o)
    else $error("reset values wrong");
  a_ctrl_write: assert property (
    !$stable({comparator_on_o, speed_power_select_o, hysteresis_on_o}) |-> $past(wb_ack_o, 2))
    else $error("control changed without write");
endmodule : cmpctl_checker
bind cmpctl_top cmpctl_checker i_cmpctl_checker (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i,
  .wb_ack_o, .analog_raw_i, .pin_direction_i, .result_pin_oe_o, .comparator_on_o,
  .speed_power_select_o, .hysteresis_on_o, .irq_o);
`default_nettype wire

// ==== dv/cmpctl_top_tb_top.sv ====
// Self-checking bench for the comparator control block.
// Assumes the analog model and the bound checker are compiled alongside.
`timescale 1ns/100ps
`default_nettype none
module cmpctl_top_tb_top import cmpctl_pkg::*; ;
  logic clk_i = 1'b0, rst_i = 1'b1, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
  logic pin_direction_i = 1'b0, tmr_run = 1'b0, wb_ack_o, analog_raw_i, comparator_on_o;
  logic speed_power_select_o, hysteresis_on_o, minus_input_select_o, timer_clk_src_i;
  logic timer_gate_o, result_pin_o, result_pin_oe_o, irq_o;
  logic [1:0] plus_input_select_o;
  logic [7:0] wb_adr_i = 8'h00;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o, rd;
  logic [5:0][7:0] lvl = '0;
  int errors = 0, compares = 0, cyc_n = 0;
  cmpctl_top i_cmpctl_top (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
    .wb_sel_i(4'hF), .wb_dat_i, .wb_dat_o, .wb_ack_o, .analog_raw_i, .comparator_on_o,
    .speed_power_select_o, .hysteresis_on_o, .plus_input_select_o, .minus_input_select_o,
    .timer_clk_src_i, .pin_direction_i, .timer_gate_o, .result_pin_o, .result_pin_oe_o,
    .port_pins_i(6'h3F), .port_analog_i(6'h05), .irq_o);
  cmpctl_analog_model i_cmpctl_analog_model (.clk_i, .on_i(comparator_on_o),
    .plus_sel_i(plus_input_select_o), .minus_sel_i(minus_input_select_o), .level_i(lvl),
    .tmr_run_i(tmr_run), .raw_o(analog_raw_i), .tmr_clk_o(timer_clk_src_i));
  initial forever #2 clk_i = ~clk_i;
  task automatic finish_test();
    $display("errors=%0d compares=%0d", errors, compares);
    if (errors == 0 && compares > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : finish_test
  always @(posedge clk_i) begin
    cyc_n++;
    if (cyc_n == 5000) begin
      errors++;
      finish_test();
    end
  end
  task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      errors++;
      $display("[ERR] %s exp %h got %h", s, e, g);
    end
  endtask : chk
  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    do @(posedge clk_i); while (wb_ack_o !== 1'b1);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask : wb
  task automatic rdc(input logic [7:0] a, input logic [31:0] e, input string s);
    repeat (6) @(posedge clk_i);
    wb(1'b0, a, 32'h0);
    chk(s, e, rd);
  endtask : rdc
  task automatic t_regs();
    rdc(CMPCTL_OFF_CTRL_A, 32'h04, "ctrl_a");
    chk("speed", 32'h1, 32'(speed_power_select_o));
    wb(1'b1, CMPCTL_OFF_CTRL_A, 32'hFF);
    wb(1'b1, CMPCTL_OFF_CTRL_B, 32'hFF);
    rdc(CMPCTL_OFF_CTRL_A, 32'hF7, "ctrl_a");
    rdc(CMPCTL_OFF_CTRL_B, 32'hF1, "ctrl_b");
    chk("outs", 32'h1F, 32'({comparator_on_o, hysteresis_on_o, plus_input_select_o,
      minus_input_select_o}));
    rdc(CMPCTL_OFF_PORT, 32'h3A, "port");
    wb(1'b1, 8'h1C, 32'hFF);
    rdc(8'h1C, 32'h0, "unmapped");
    wb(1'b1, CMPCTL_OFF_CTRL_B, 32'h00);
    wb(1'b1, CMPCTL_OFF_CTRL_A, 32'h04);
    wb(1'b1, CMPCTL_OFF_CLEAR, 32'h01);
  endtask : t_regs
  task automatic t_irq();
    lvl <= {8'h00, 8'hC8, 8'h32, 8'h64, 8'h0A, 8'h64};
    wb(1'b1, CMPCTL_OFF_IRQ_EN, 32'h01);
    wb(1'b1, CMPCTL_OFF_CTRL_B, 32'h80);
    wb(1'b1, CMPCTL_OFF_CTRL_A, 32'h84);
    rdc(CMPCTL_OFF_STATUS, 32'h01, "status");
    chk("irq", 32'h1, 32'(irq_o));
    wb(1'b1, CMPCTL_OFF_IRQ_EN, 32'h00);
    rdc(CMPCTL_OFF_MIRROR, 32'h01, "mirror");
    chk("irq_mask", 32'h0, 32'(irq_o));
    wb(1'b1, CMPCTL_OFF_CLEAR, 32'h01);
    wb(1'b1, CMPCTL_OFF_CTRL_A, 32'h94);
    rdc(CMPCTL_OFF_CTRL_A, 32'h94, "ctrl_a");
    rdc(CMPCTL_OFF_STATUS, 32'h00, "status");
    wb(1'b1, CMPCTL_OFF_CTRL_B, 32'h40);
    wb(1'b1, CMPCTL_OFF_CTRL_A, 32'h14);
    wb(1'b1, CMPCTL_OFF_CTRL_A, 32'h04);
    rdc(CMPCTL_OFF_STATUS, 32'h01, "status");
    wb(1'b1, CMPCTL_OFF_CLEAR, 32'h01);
    wb(1'b1, CMPCTL_OFF_CTRL_B, 32'h00);
  endtask : t_irq
  task automatic t_chan();
    wb(1'b1, CMPCTL_OFF_CTRL_A, 32'h84);
    for (int c = 0; c < 4; c++) begin
      wb(1'b1, CMPCTL_OFF_CTRL_B, 32'(c * 16));
      rdc(CMPCTL_OFF_MIRROR, 32'(c % 2 == 0 && c < 3), "chan");
    end
    wb(1'b1, CMPCTL_OFF_CTRL_B, 32'h01);
    rdc(CMPCTL_OFF_MIRROR, 32'h0, "minus");
  endtask : t_chan
  task automatic t_pin();
    wb(1'b1, CMPCTL_OFF_CTRL_B, 32'h00);
    wb(1'b1, CMPCTL_OFF_CTRL_A, 32'h30);
    tmr_run <= 1'b1;
    rdc(CMPCTL_OFF_MIRROR, 32'h1, "mirror");
    tmr_run <= 1'b0;
    chk("pin", 32'h3, 32'({result_pin_o, result_pin_oe_o}));
    pin_direction_i <= 1'b1;
    rdc(CMPCTL_OFF_MIRROR, 32'h1, "mirror");
    chk("oe_dir", 32'h0, 32'(result_pin_oe_o));
    pin_direction_i <= 1'b0;
    wb(1'b1, CMPCTL_OFF_CTRL_A, 32'hB1);
    rdc(CMPCTL_OFF_MIRROR, 32'h0, "mirror");
    chk("gate_hold", 32'h1, 32'(timer_gate_o));
    tmr_run <= 1'b1;
    rdc(CMPCTL_OFF_MIRROR, 32'h0, "mirror");
    chk("gate_sync", 32'h0, 32'(timer_gate_o));
    tmr_run <= 1'b0;
  endtask : t_pin
  initial begin
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    t_regs();
    t_irq();
    t_chan();
    t_pin();
    finish_test();
  end
endmodule : cmpctl_top_tb_top
`default_nettype wire

// ==== pkg/cmpctl_pkg.sv ====
// Comparator control block: register offsets, field positions, reset values.
// Assumes a 32-bit classic Wishbone slave port, one register per aligned word.
package cmpctl_pkg;
  // Byte offsets
  localparam logic [7:0] CMPCTL_OFF_CTRL_A = 8'h00;
  localparam logic [7:0] CMPCTL_OFF_CTRL_B = 8'h04;
  localparam logic [7:0] CMPCTL_OFF_MIRROR = 8'h08;
  localparam logic [7:0] CMPCTL_OFF_STATUS = 8'h0C;
  localparam logic [7:0] CMPCTL_OFF_CLEAR = 8'h10;
  localparam logic [7:0] CMPCTL_OFF_IRQ_EN = 8'h14;
  localparam logic [7:0] CMPCTL_OFF_PORT = 8'h18;
  // Control A fields
  localparam int CMPCTL_A_ON = 7;
  localparam int CMPCTL_A_RESULT = 6;
  localparam int CMPCTL_A_PIN = 5;
  localparam int CMPCTL_A_INV = 4;
  localparam int CMPCTL_A_SPEED = 2;
  localparam int CMPCTL_A_HYS = 1;
  localparam int CMPCTL_A_SYNC = 0;
  // Control B fields
  localparam int CMPCTL_B_RISE = 7;
  localparam int CMPCTL_B_FALL = 6;
  localparam int CMPCTL_B_PLUS_HI = 5;
  localparam int CMPCTL_B_PLUS_LO = 4;
  localparam int CMPCTL_B_MINUS = 0;
  // Writable masks and reset values
  localparam logic [7:0] CMPCTL_A_WMASK = 8'hB7;
  localparam logic [7:0] CMPCTL_B_WMASK = 8'hF1;
  localparam logic [7:0] CMPCTL_A_RESET = 8'h04;
  localparam logic [7:0] CMPCTL_B_RESET = 8'h00;
  // Plus input channel codes
  localparam logic [1:0] CMPCTL_PLUS_PIN = 2'h0;
  localparam logic [1:0] CMPCTL_PLUS_DAC = 2'h1;
  localparam logic [1:0] CMPCTL_PLUS_FVR = 2'h2;
  localparam logic [1:0] CMPCTL_PLUS_GND = 2'h3;
  // Port register width and unmapped read value
  localparam int CMPCTL_PORT_W = 6;
  localparam logic [31:0] CMPCTL_UNMAPPED = 32'h0000_0000;
endpackage : cmpctl_pkg
